/* verilog/lcdh_pkg.sv */
// Functional notes
// - Register select high reaches the data holding register, low the instruction latch.
// - Instruction latch is write-only; its contents never go back to the host.
// - Data written by the host is stored into the selected character or glyph RAM.
// - Setting an address fetches that RAM byte into the data holding register.
// - After a host data write the next RAM location is selected.
// - After a host data read the next location is prefetched into the holding register.
// - Read/write and select decode: instruction write, status read, data write, data read.
// - Busy stays high while any internal operation from a host access runs.
// - Any instruction presented while busy is discarded.
// - Status read drives the busy indicator on data bit 7.
// - Address counter on a status read is meaningless while busy.
// - Address set picks character or glyph RAM, then loads the address counter.
// - Each data write or read steps the counter by one, up or down.
// - Status read with busy low places the address counter on bits 0 to 6.
// - Address counter addresses both RAMs and gives the cursor position.
// - Timing generator makes strobes for host instructions and RAM refresh needs.
// - Host RAM accesses are arbitrated against refresh reads, avoiding display disturbance.
// - Timing generator also makes the transfer signals for expansion segment drivers.
package lcdh_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int XFER_HIGH_NS = 800;
    localparam int XFER_HIGH_CYC = (XFER_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GEN_PERIOD_CYC = 2 * XFER_HIGH_CYC;
    localparam int EXEC_NS = 2000;
    localparam int EXEC_CYC = (EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int GEN_W = 5;
    localparam int EXEC_W = 6;
    localparam logic [GEN_W-1:0] GEN_LAST = GEN_W'(GEN_PERIOD_CYC - 1);
    localparam logic [GEN_W-1:0] REFRESH_SLOT = 5'h00;
    localparam logic [GEN_W-1:0] HOST_SLOT = GEN_W'(XFER_HIGH_CYC);
    localparam logic [GEN_W-1:0] XFER_HIGH_END = GEN_W'(XFER_HIGH_CYC);
    localparam logic [EXEC_W-1:0] EXEC_LOAD = EXEC_W'(EXEC_CYC - 1);
    localparam logic [EXEC_W-1:0] EXEC_ZERO = 6'h00;

    // ****************************************
    // Widths and instruction fields
    // ****************************************
    localparam int AC_W = 7;
    localparam int DD_DEPTH = 128;
    localparam int CG_DEPTH = 64;
    localparam int CG_AW = 6;
    localparam logic [AC_W-1:0] SCAN_LAST = 7'h4F;
    localparam logic [AC_W-1:0] AC_ONE = 7'h01;
    localparam int BUSY_BIT = 7;
    localparam int DD_SET_BIT = 7;
    localparam logic [1:0] CG_SET_CODE = 2'h1;
    localparam logic [5:0] ENTRY_CODE = 6'h01;
    localparam int DIR_BIT = 1;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARB = 2'b01,
        ST_SETTLE = 2'b10
    } lcdh_fsm_t;

    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_STORE = 2'b01,
        OP_FETCH = 2'b10
    } lcdh_op_t;

    typedef struct packed {
        logic rs;
        logic rw;
        logic e;
        logic [7:0] db;
    } lcdh_pins_t;

    localparam int PINS_W = $bits(lcdh_pins_t);

    typedef struct packed {
        lcdh_fsm_t fsm;
        lcdh_op_t op;
        logic e_d;
        logic rs_cap;
        logic rw_cap;
        logic [7:0] wdata;
        logic [7:0] ir;
        logic [7:0] dhr;
        logic [AC_W-1:0] ac;
        logic sel_glyph;
        logic dir_up;
        logic busy;
        logic [EXEC_W-1:0] exec_cnt;
        logic [GEN_W-1:0] gen_cnt;
        logic [AC_W-1:0] scan;
        logic [AC_W-1:0] refresh_addr;
        logic [7:0] refresh_char;
        logic xfer_clk;
        logic xfer_load;
        logic [7:0] dout;
        logic doe;
        logic [DD_DEPTH-1:0][7:0] ddram;
        logic [CG_DEPTH-1:0][7:0] cgram;
    } lcdh_state_t;

endpackage

// ****************************************
// Three-stage pin synchroniser with agreement filter
// ****************************************
module lcdh_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Raw and filtered levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    // Stages 1..3 and the accepted level
    logic [3:0][W-1:0] st;
    logic [3:0][W-1:0] next_st;

    // Stage 1 feeds stage 2 only; filter compares stages 2 and 3
    always_comb
    begin
        next_st[0] = din;
        next_st[1] = st[0];
        next_st[2] = st[1];
        next_st[3] = st[3];
        for (int i = 0; i < W; i++)
        begin
            if (st[1][i] == st[2][i])
            begin
                next_st[3][i] = st[2][i];
            end
        end
        if (!resetn)
        begin
            next_st = '0;
        end
    end

    // Register stage
    always_ff @(posedge core_clk)
    begin
        st <= next_st;
    end

    assign dout = st[3];
endmodule

/* verilog/lcdh_host_if.sv */
module lcdh_host_if (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Host pins
    input wire logic register_select,
    input wire logic read_select,
    input wire logic enable_strobe,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    // Display side
    output logic [6:0] cursor_addr,
    output logic [6:0] refresh_addr,
    output logic [7:0] refresh_char,
    output logic xfer_clk,
    output logic xfer_load
);

    // ****************************************
    // Pin synchronisation
    // ****************************************
    lcdh_pkg::lcdh_pins_t pin_raw;
    lcdh_pkg::lcdh_pins_t pin;
    logic [lcdh_pkg::PINS_W-1:0] pin_sync;

    // Bundle raw pins
    assign pin_raw = '{rs: register_select, rw: read_select, e: enable_strobe, db: host_data_in};

    lcdh_pin_sync #(
        .W(lcdh_pkg::PINS_W)
    ) u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .din(pin_raw),
        .dout(pin_sync)
    );

    assign pin = lcdh_pkg::lcdh_pins_t'(pin_sync);

    // ****************************************
    // State
    // ****************************************
    lcdh_pkg::lcdh_state_t r;
    lcdh_pkg::lcdh_state_t next_r;
    logic ev_fall;
    logic host_slot;
    logic [lcdh_pkg::AC_W-1:0] ac_step;
    logic [7:0] rd_byte;

    // Strobe edge, host slot, counter step and RAM read port
    always_comb
    begin
        ev_fall = r.e_d & ~pin.e;
        host_slot = (r.gen_cnt == lcdh_pkg::HOST_SLOT);
        ac_step = r.dir_up ? (r.ac + lcdh_pkg::AC_ONE) : (r.ac - lcdh_pkg::AC_ONE);
        // Counter addresses both RAMs
        if (r.sel_glyph)
        begin
            rd_byte = r.cgram[r.ac[lcdh_pkg::CG_AW-1:0]];
        end
        else
        begin
            rd_byte = r.ddram[r.ac];
        end
    end

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb
    begin
        next_r = r;
        next_r.e_d = pin.e;

        // Levels and write data followed while strobe high, frozen at the fall
        if (pin.e)
        begin
            next_r.rs_cap = pin.rs;
            next_r.rw_cap = pin.rw;
            next_r.wdata = pin.db;
        end

        // Read data driven only during a read strobe; latch never readable
        next_r.doe = pin.e & pin.rw;
        if (pin.rs)
        begin
            next_r.dout = r.dhr;
        end
        else
        begin
            // Counter bits shown even while busy; host must ignore them then
            next_r.dout = {r.busy, r.ac};
        end

        // Timing generator: one refresh slot and one host slot per period
        if (r.gen_cnt == lcdh_pkg::GEN_LAST)
        begin
            next_r.gen_cnt = '0;
        end
        else
        begin
            next_r.gen_cnt = r.gen_cnt + 5'h01;
        end
        // Expansion shift clock, high for the first half of each period
        next_r.xfer_clk = (next_r.gen_cnt < lcdh_pkg::XFER_HIGH_END);

        // Refresh read owns its own slot, so host writes never collide with it
        if (r.gen_cnt == lcdh_pkg::REFRESH_SLOT)
        begin
            next_r.refresh_char = r.ddram[r.scan];
            next_r.refresh_addr = r.scan;
            next_r.xfer_load = (r.scan == lcdh_pkg::SCAN_LAST);
            if (r.scan == lcdh_pkg::SCAN_LAST)
            begin
                next_r.scan = '0;
            end
            else
            begin
                next_r.scan = r.scan + lcdh_pkg::AC_ONE;
            end
        end

        // Host access sequencer
        case (r.fsm)
            lcdh_pkg::ST_IDLE:
            begin
                // Only acted on when idle, so accesses during busy are dropped
                if (ev_fall && !r.rw_cap)
                begin
                    next_r.busy = 1'b1;
                    next_r.fsm = lcdh_pkg::ST_SETTLE;
                    next_r.exec_cnt = lcdh_pkg::EXEC_LOAD;
                    if (!r.rs_cap)
                    begin
                        next_r.ir = r.wdata;
                        if (r.wdata[lcdh_pkg::DD_SET_BIT])
                        begin
                            next_r.sel_glyph = 1'b0;
                            next_r.ac = r.wdata[lcdh_pkg::AC_W-1:0];
                            next_r.op = lcdh_pkg::OP_FETCH;
                            next_r.fsm = lcdh_pkg::ST_ARB;
                        end
                        else if (r.wdata[7:6] == lcdh_pkg::CG_SET_CODE)
                        begin
                            next_r.sel_glyph = 1'b1;
                            next_r.ac = {1'b0, r.wdata[lcdh_pkg::CG_AW-1:0]};
                            next_r.op = lcdh_pkg::OP_FETCH;
                            next_r.fsm = lcdh_pkg::ST_ARB;
                        end
                        else if (r.wdata[7:2] == lcdh_pkg::ENTRY_CODE)
                        begin
                            next_r.dir_up = r.wdata[lcdh_pkg::DIR_BIT];
                        end
                    end
                    else
                    begin
                        // Data write: holding register then RAM
                        next_r.dhr = r.wdata;
                        next_r.op = lcdh_pkg::OP_STORE;
                        next_r.fsm = lcdh_pkg::ST_ARB;
                    end
                end
                else if (ev_fall && r.rs_cap && !r.busy)
                begin
                    // Data read done: step and prefetch the next byte
                    next_r.busy = 1'b1;
                    next_r.ac = ac_step;
                    next_r.op = lcdh_pkg::OP_FETCH;
                    next_r.fsm = lcdh_pkg::ST_ARB;
                    next_r.exec_cnt = lcdh_pkg::EXEC_LOAD;
                end
            end
            lcdh_pkg::ST_ARB:
            begin
                // Wait for the host slot; costs up to one generator period of busy
                if (host_slot)
                begin
                    if (r.op == lcdh_pkg::OP_STORE)
                    begin
                        if (r.sel_glyph)
                        begin
                            next_r.cgram[r.ac[lcdh_pkg::CG_AW-1:0]] = r.dhr;
                        end
                        else
                        begin
                            next_r.ddram[r.ac] = r.dhr;
                        end
                        next_r.ac = ac_step;
                    end
                    else
                    begin
                        next_r.dhr = rd_byte;
                    end
                    next_r.op = lcdh_pkg::OP_NONE;
                    next_r.fsm = lcdh_pkg::ST_SETTLE;
                end
            end
            lcdh_pkg::ST_SETTLE:
            begin
                if (r.exec_cnt == lcdh_pkg::EXEC_ZERO)
                begin
                    next_r.busy = 1'b0;
                    next_r.fsm = lcdh_pkg::ST_IDLE;
                end
                else
                begin
                    next_r.exec_cnt = r.exec_cnt - 6'h01;
                end
            end
            default:
            begin
                next_r.fsm = lcdh_pkg::ST_IDLE;
                next_r.busy = 1'b0;
            end
        endcase

        // Synchronous reset, counting upward by default
        if (!resetn)
        begin
            next_r = '0;
            next_r.dir_up = 1'b1;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge core_clk)
    begin
        r <= next_r;
    end

    // Outputs all straight from the state register
    assign host_data_out = r.dout;
    assign host_data_oe = r.doe;
    assign cursor_addr = r.ac;
    assign refresh_addr = r.refresh_addr;
    assign refresh_char = r.refresh_char;
    assign xfer_clk = r.xfer_clk;
    assign xfer_load = r.xfer_load;

    // ****************************************
    // Assertions
    // ****************************************
    localparam int BUSY_MAX_CYC = lcdh_pkg::GEN_PERIOD_CYC + lcdh_pkg::EXEC_CYC + 4;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    status_busy_a: assert property ($past(pin.e & pin.rw & ~pin.rs) |-> host_data_out[7] == $past(r.busy))
        else $error("busy not on bit 7 during status read");
    status_count_a: assert property ($past(pin.e & pin.rw & ~pin.rs & ~r.busy) |-> host_data_out[6:0] == $past(r.ac))
        else $error("address counter not on bits 0 to 6");
    drive_read_a: assert property (host_data_oe |-> $past(pin.e & pin.rw))
        else $error("data bus driven outside a read strobe");
    busy_raise_a: assert property ((r.fsm == lcdh_pkg::ST_IDLE && ev_fall && !r.rw_cap) |=> r.busy)
        else $error("busy not raised after a write");
    busy_bound_a: assert property ($rose(r.busy) |-> r.busy until (r.fsm == lcdh_pkg::ST_IDLE))
        else $error("busy dropped while work remains");
    busy_end_a: assert property ($rose(r.busy) |-> ##[1:BUSY_MAX_CYC] !r.busy)
        else $error("busy held too long");
    // The slot cycle of a running fetch may load the holding register on its own
    ignore_busy_a: assert property ((r.busy && ev_fall && !(r.fsm == lcdh_pkg::ST_ARB && host_slot))
        |=> r.ir == $past(r.ir) && r.dhr == $past(r.dhr))
        else $error("access acted on while busy");
    write_step_a: assert property ((r.fsm == lcdh_pkg::ST_ARB && host_slot && r.op == lcdh_pkg::OP_STORE)
        |=> r.ac == $past(ac_step))
        else $error("counter not stepped after a data write");
    store_a: assert property ((r.fsm == lcdh_pkg::ST_ARB && host_slot && r.op == lcdh_pkg::OP_STORE && !r.sel_glyph)
        |=> r.ddram[$past(r.ac)] == $past(r.dhr))
        else $error("written byte missing from character RAM");
    fetch_a: assert property ((r.fsm == lcdh_pkg::ST_ARB && host_slot && r.op == lcdh_pkg::OP_FETCH)
        |=> r.dhr == $past(rd_byte))
        else $error("holding register not loaded from RAM");
    host_slot_a: assert property ((r.fsm == lcdh_pkg::ST_ARB && !host_slot) |=> r.fsm == lcdh_pkg::ST_ARB)
        else $error("host access outside its slot");
    addr_set_a: assert property ((r.fsm == lcdh_pkg::ST_IDLE && ev_fall && !r.rw_cap && !r.rs_cap && r.wdata[7])
        |=> r.ac == $past(r.wdata[6:0]) && !r.sel_glyph)
        else $error("address set did not load the counter");
    xfer_high_a: assert property ($rose(xfer_clk) |-> xfer_clk [*8])
        else $error("transfer clock high phase too short");

    // ****************************************
    // Assertions: host routing
    // ****************************************
    // Read data source and bus release during writes
    data_route_a: assert property ($past(pin.e & pin.rw & pin.rs) |-> host_data_out == $past(r.dhr))
        else $error("data read not served from the holding register");
    no_drive_a: assert property ((pin.e && !pin.rw) |=> !host_data_oe)
        else $error("data bus driven during a write strobe");

    // Accepted accesses land in the right place
    ir_load_a: assert property ((r.fsm == lcdh_pkg::ST_IDLE && ev_fall && !r.rw_cap && !r.rs_cap)
        |=> r.ir == $past(r.wdata))
        else $error("instruction latch not loaded");
    dhr_load_a: assert property ((r.fsm == lcdh_pkg::ST_IDLE && ev_fall && !r.rw_cap && r.rs_cap)
        |=> r.dhr == $past(r.wdata) && r.op == lcdh_pkg::OP_STORE)
        else $error("holding register not loaded by a data write");
    glyph_set_a: assert property ((r.fsm == lcdh_pkg::ST_IDLE && ev_fall && !r.rw_cap && !r.rs_cap
        && r.wdata[7:6] == lcdh_pkg::CG_SET_CODE)
        |=> r.ac == {1'b0, $past(r.wdata[lcdh_pkg::CG_AW-1:0])} && r.sel_glyph)
        else $error("glyph address set did not load the counter");
    entry_dir_a: assert property ((r.fsm == lcdh_pkg::ST_IDLE && ev_fall && !r.rw_cap && !r.rs_cap
        && r.wdata[7:2] == lcdh_pkg::ENTRY_CODE) |=> r.dir_up == $past(r.wdata[lcdh_pkg::DIR_BIT]))
        else $error("step direction not taken from the entry code");
    read_step_a: assert property ((r.fsm == lcdh_pkg::ST_IDLE && ev_fall && r.rw_cap && r.rs_cap)
        |=> r.ac == $past(ac_step) && r.op == lcdh_pkg::OP_FETCH)
        else $error("counter not stepped after a data read");
    glyph_store_a: assert property ((r.fsm == lcdh_pkg::ST_ARB && host_slot && r.op == lcdh_pkg::OP_STORE && r.sel_glyph)
        |=> r.cgram[$past(r.ac[lcdh_pkg::CG_AW-1:0])] == $past(r.dhr))
        else $error("written byte missing from glyph RAM");
    busy_state_a: assert property (r.busy == (r.fsm != lcdh_pkg::ST_IDLE))
        else $error("busy does not match sequencer activity");

    // ****************************************
    // Assertions: refresh and timing
    // ****************************************
    // Refresh reads its own slot; host writes only in theirs
    refresh_read_a: assert property ((r.gen_cnt == lcdh_pkg::REFRESH_SLOT)
        |=> refresh_addr == $past(r.scan) && refresh_char == $past(r.ddram[r.scan]))
        else $error("refresh read not taken at its slot");
    ram_quiet_a: assert property ((r.gen_cnt != lcdh_pkg::HOST_SLOT) |=> r.ddram == $past(r.ddram))
        else $error("character RAM written outside the host slot");
    load_pulse_a: assert property ((r.gen_cnt == lcdh_pkg::REFRESH_SLOT && r.scan == lcdh_pkg::SCAN_LAST) |=> xfer_load)
        else $error("expansion load not raised after the last scan");

    instr_c: cover property (r.fsm == lcdh_pkg::ST_IDLE && ev_fall && !r.rw_cap && !r.rs_cap);
    dwrite_c: cover property (r.fsm == lcdh_pkg::ST_ARB && host_slot && r.op == lcdh_pkg::OP_STORE);
    dread_c: cover property (r.fsm == lcdh_pkg::ST_IDLE && ev_fall && r.rw_cap && r.rs_cap);
    busy_poll_c: cover property (host_data_oe && host_data_out[7]);
    glyph_store_c: cover property (r.fsm == lcdh_pkg::ST_ARB && host_slot && r.op == lcdh_pkg::OP_STORE && r.sel_glyph);
endmodule

/* testbench/lcdh_host_model.sv */
// ****************************************
// Host microcontroller bus model
// ****************************************
module lcdh_host_model (
    // Clock
    input wire logic core_clk,
    // Device side of the data pins
    input wire logic [7:0] dev_out,
    input wire logic dev_oe,
    // Pin bundle seen by the device
    output lcdh_pkg::lcdh_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ns;

    logic rs_q = 1'b0;
    logic rw_q = 1'b0;
    logic e_q = 1'b0;
    logic drv = 1'b0;
    logic [7:0] db_q = 8'h00;

    // Wire level; an undriven bus shows the inverse of the host's last write data
    always_comb
    begin
        pins.rs = rs_q;
        pins.rw = rw_q;
        pins.e = e_q;
        pins.db = dev_oe ? dev_out : (drv ? db_q : ~db_q);
    end

    // One strobe cycle; select and direction held well past the fall
    task automatic bus_cycle(input logic rs, input logic rw, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge core_clk);
        rs_q <= rs;
        rw_q <= rw;
        drv <= ~rw;
        if (!rw)
        begin
            db_q <= wd;
        end
        repeat (2) @(posedge core_clk);
        e_q <= 1'b1;
        repeat (8) @(posedge core_clk);
        rd = pins.db;
        e_q <= 1'b0;
        repeat (8) @(posedge core_clk);
        drv <= 1'b0;
    endtask

    // Poll status until the busy bit reads low, bounded
    task automatic wait_ready(output logic [7:0] st);
        st = 8'hFF;
        for (int i = 0; i < 30 && st[7] !== 1'b0; i++)
        begin
            bus_cycle(1'b0, 1'b1, 8'h00, st);
        end
    endtask
endmodule

/* testbench/lcd_host_register_interface_bench.sv */
module lcd_host_register_interface_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic core_clk;
    logic resetn;
    lcdh_pkg::lcdh_pins_t pins;
    logic [7:0] dout;
    logic doe;
    logic [6:0] cursor;
    logic [6:0] raddr;
    logic [7:0] rchar;
    logic xclk;
    logic xload;
    int fail_count = 0;
    int num_checks = 0;

    // ****************************************
    // Device and host model
    // ****************************************
    lcdh_host_if u_lcdh_host_if (
        .core_clk(core_clk),
        .resetn(resetn),
        .register_select(pins.rs),
        .read_select(pins.rw),
        .enable_strobe(pins.e),
        .host_data_in(pins.db),
        .host_data_out(dout),
        .host_data_oe(doe),
        .cursor_addr(cursor),
        .refresh_addr(raddr),
        .refresh_char(rchar),
        .xfer_clk(xclk),
        .xfer_load(xload)
    );

    lcdh_host_model u_lcdh_host_model (
        .core_clk(core_clk),
        .dev_out(dout),
        .dev_oe(doe),
        .pins(pins)
    );

    // ****************************************
    // Helpers
    // ****************************************
    task automatic summarize();
        if (fail_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Write then wait until the device is idle again
    task automatic wr(input logic rs, input logic [7:0] d);
        logic [7:0] st;
        u_lcdh_host_model.bus_cycle(rs, 1'b0, d, st);
        u_lcdh_host_model.wait_ready(st);
        check({7'h00, st[7]}, 8'h00);
    endtask

    task automatic rdx(input logic rs, output logic [7:0] d);
        u_lcdh_host_model.bus_cycle(rs, 1'b1, 8'h00, d);
    endtask

    // Data read, its prefetch allowed to finish
    task automatic rd_data(input logic [7:0] exp);
        logic [7:0] d;
        rdx(1'b1, d);
        check(d, exp);
        u_lcdh_host_model.wait_ready(d);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        logic [7:0] d;
        check({7'h00, doe}, 8'h00);
        rdx(1'b0, d);
        check(d, 8'h00);
        check({1'b0, cursor}, 8'h00);
    endtask

    task automatic t_write();
        logic [7:0] d;
        wr(1'b0, 8'h90);
        check({1'b0, cursor}, 8'h10);
        u_lcdh_host_model.bus_cycle(1'b1, 1'b0, 8'hA5, d);
        rdx(1'b0, d);
        check({7'h00, d[7]}, 8'h01);
        u_lcdh_host_model.wait_ready(d);
        wr(1'b1, 8'h5A);
        rdx(1'b0, d);
        check(d, 8'h12);
    endtask

    task automatic t_read();
        logic [7:0] d;
        wr(1'b0, 8'h90);
        rd_data(8'hA5);
        rd_data(8'h5A);
        rdx(1'b0, d);
        check(d, 8'h12);
    endtask

    // Downward stepping, direction restored afterwards
    task automatic t_down();
        wr(1'b0, 8'h04);
        wr(1'b0, 8'hA0);
        wr(1'b1, 8'h11);
        check({1'b0, cursor}, 8'h1F);
        wr(1'b0, 8'h06);
    endtask

    // Same address in both memories must stay apart
    task automatic t_glyph();
        wr(1'b0, 8'h85);
        wr(1'b1, 8'h77);
        wr(1'b0, 8'h45);
        check({1'b0, cursor}, 8'h05);
        wr(1'b1, 8'h1F);
        wr(1'b0, 8'h45);
        rd_data(8'h1F);
        wr(1'b0, 8'h85);
        rd_data(8'h77);
    endtask

    // Second instruction falls while busy and must vanish
    task automatic t_busy();
        logic [7:0] d;
        u_lcdh_host_model.bus_cycle(1'b0, 1'b0, 8'hB0, d);
        u_lcdh_host_model.bus_cycle(1'b0, 1'b0, 8'hC0, d);
        u_lcdh_host_model.wait_ready(d);
        check(d, 8'h30);
    endtask

    // Refresh scan and expansion signals; every wait is bounded and a lapse shows as a mismatch
    task automatic t_refresh();
        int n;
        for (n = 0; raddr !== 7'h10 && n < 3000; n++)
            @(posedge core_clk);
        check({1'b0, raddr}, 8'h10);
        check(rchar, 8'hA5);
        for (n = 0; xclk !== 1'b0 && n < 100; n++)
            @(posedge core_clk);
        for (n = 0; xclk !== 1'b1 && n < 100; n++)
            @(posedge core_clk);
        for (n = 0; xclk === 1'b1 && n < 100; n++)
            @(posedge core_clk);
        check(8'(n), 8'h10);
        for (n = 0; xload !== 1'b1 && n < 3000; n++)
            @(posedge core_clk);
        check({7'h00, xload}, 8'h01);
        for (n = 0; xload === 1'b1 && n < 100; n++)
            @(posedge core_clk);
        check(8'(n), 8'h20);
    endtask

    // ****************************************
    // Clock, reset, sequence, watchdog
    // ****************************************
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Reset held two edges; the pin stages clear on the first one as well
    initial
    begin
        resetn = 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset();
        t_write();
        t_read();
        t_down();
        t_glyph();
        t_busy();
        t_refresh();
        summarize();
    end

    initial
    begin
        repeat (40000) @(posedge core_clk);
        fail_count++;
        summarize();
    end
endmodule
